// ### src/ssu_defs.vh
// Constants of the settings update and nonvolatile memory sequencer.
// Assumes: included by bare name; definitions only.
`ifndef SSU_DEFS_VH
`define SSU_DEFS_VH
// Register byte addresses on the serial port
`define SSU_AW          13
`define SSU_SYSCTL_ADDR 13'h230
`define SSU_APPLY_ADDR  13'h232
`define SSU_LIST_BASE   13'ha00
`define SSU_LIST_LAST   13'haff
`define SSU_XSTAT_ADDR  13'hb00
`define SSU_XERR_ADDR   13'hb01
`define SSU_NVCTL_ADDR  13'hb02
`define SSU_SAVE_ADDR   13'hb03
// System control fields and reset value
`define SSU_SC_SOFT_SYNC 0
`define SSU_SC_DIST_PD   1
`define SSU_SC_SYNC_PD   2
`define SSU_SC_RUNT_DIS  3
`define SSU_SC_RESET     4'h0
// Nonvolatile control fields
`define SSU_NV_WR_EN     0
`define SSU_NV_LOAD      1
// Command list encoding
`define SSU_CMD_SPECIAL  7
`define SSU_OP_APPLY     8'h80
`define SSU_OP_END       8'hff
`define SSU_LIST_FILL    8'hff
// Serial frame: 16 instruction bits then 8 data bits
`define SSU_INSTR_BITS   5'd16
`define SSU_FRAME_BITS   5'd24
`define SSU_NVM_AW       10
`endif

// ### src/ssu_settings_top.v
// Settings update and nonvolatile memory sequencer: system control,
// buffered-to-active update, command list and save/restore engine.
// Assumes: serial pins asynchronous; memory port on mclk, one request
// outstanding, ack is a one-cycle pulse.
`timescale 1ns/100ps
`include "ssu_defs.vh"
// Overview of operation
// - System control bit 3 set disables runt-pulse suppression; reset keeps it on.
// - System control bit 2 set powers down the alignment function.
// - System control bit 1 set powers down the distribution reference.
// - Soft alignment bit at 1 holds selected channels static, inverted pin.
// - Soft alignment bit falling from 1 to 0 fires an alignment event.
// - Writing 1 to update bit copies all buffer registers into active ones.
// - The copy happens on the next serial clock rising edge.
// - Update bit clears itself after the copy.
// - Command list at 0xA00..0xAFF holds start addresses and byte counts.
// - Command byte with bit 7 clear is a consecutive-register transfer.
// - Low seven bits hold transfer length minus one.
// - Next two list bytes give the start address, high byte first.
// - Command with bit 7 set is special: apply-update or end-of-list.
// - Apply-update has the same effect as writing the update bit.
// - End-of-list stops the list walk and ends the transfer.
// - Reset list moves the system control register, then issues apply-update.
// - Save trigger starts buffer-to-memory copy and clears when done.
// - Status bit reads 1 while a transfer runs, 0 when complete.
// - Error bit reads 1 when bad data came from memory.
module ssu_settings_top (
  input  wire                  mclk,         // 250 MHz block clock
  input  wire                  rst_n,        // Async reset, active low
  input  wire                  spi_cs_n,     // Serial chip select
  input  wire                  spi_sclk,     // Serial clock pin
  input  wire                  spi_sdi,      // Serial data in
  output wire                  spi_sdo,      // Serial data out
  output wire                  spi_sdo_oe,   // Serial out enable
  output reg                   nvm_req,      // Memory request level
  output reg                   nvm_we,       // Request is a write
  output reg [`SSU_NVM_AW-1:0] nvm_addr,     // Memory byte address
  output reg  [7:0]            nvm_wdata,    // Memory write byte
  input  wire [7:0]            nvm_rdata,    // Memory read byte
  input  wire                  nvm_ack,      // Request done pulse
  input  wire                  nvm_rerr,     // Read data bad, with ack
  output reg                   runt_supp_en, // Runt suppression on
  output reg                   sync_pd,      // Alignment powered down
  output reg                   dist_ref_pd,  // Distribution ref down
  output reg                   align_hold,   // Channels held static
  output reg                   align_event   // Alignment pulse
);
  localparam [`SSU_AW-1:0] SC_A = `SSU_SYSCTL_ADDR;
  // Walker states, one-hot: S_CMD decodes a byte,
  // S_AHI and S_ALO fetch the start address,
  // S_XFER raises a request, S_WAIT holds it
  // until the ack. The last list byte ends any
  // walk, so a list without end code cannot loop.
  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_CMD  = 6'h02;
  localparam [5:0] S_AHI  = 6'h04;
  localparam [5:0] S_ALO  = 6'h08;
  localparam [5:0] S_XFER = 6'h10;
  localparam [5:0] S_WAIT = 6'h20;

  // Serial port side
  wire               sclk_rise;
  wire               spi_wr;
  wire [`SSU_AW-1:0] spi_addr;
  wire [7:0]         spi_wdata;
  wire [7:0]         spi_rdata;

  // Registers and walker
  reg  [3:0]         sc_buf_reg;
  reg  [3:0]         sc_act_reg;
  reg  [7:0]         list_reg [0:255];
  reg                upd_pend_reg;
  reg                wr_en_reg;
  reg                save_reg;
  reg                busy_reg;
  reg                err_reg;
  reg                dir_reg;
  reg  [5:0]         st_reg;
  reg  [5:0]         st_next;
  reg  [7:0]         ptr_reg;
  reg  [6:0]         len_reg;
  reg  [`SSU_AW-1:0] raddr_reg;
  reg                act0_d_reg;
  reg                seq_apply;
  reg                seq_wr;
  wire [7:0]         cmd = list_reg[ptr_reg];
  // Walk leaving for idle: end code or list exhausted
  wire               walk_end = (st_reg != S_IDLE) && (st_next == S_IDLE);
  // Restore start from the nonvolatile control register
  wire               load_req = spi_wr && (spi_addr == `SSU_NVCTL_ADDR)
                                && spi_wdata[`SSU_NV_LOAD];

  integer            i;

  ////////////////////////////////////////////////////////////////////
  // Reset image of the list: save system control, apply, then end
  function [7:0] list_init;
    input integer idx;
    begin
      case (idx)
        0:       list_init = 8'h00;
        1:       list_init = {3'h0, SC_A[12:8]};
        2:       list_init = SC_A[7:0];
        3:       list_init = `SSU_OP_APPLY;
        default: list_init = `SSU_LIST_FILL;
      endcase
    end
  endfunction

  // List window decode, shared by reads and writes
  function is_list;
    input [`SSU_AW-1:0] a;
    begin
      is_list = (a >= `SSU_LIST_BASE) && (a <= `SSU_LIST_LAST);
    end
  endfunction

  // Register read view shared by serial reads and the save walk
  function [7:0] reg_rd;
    input [`SSU_AW-1:0] a;
    begin
      if (a == `SSU_SYSCTL_ADDR)
        reg_rd = {4'h0, sc_buf_reg};
      else if (a == `SSU_APPLY_ADDR)
        reg_rd = {7'h00, upd_pend_reg};
      else if (is_list(a))
        reg_rd = list_reg[a[7:0]];
      else if (a == `SSU_XSTAT_ADDR)
        reg_rd = {7'h00, busy_reg};
      else if (a == `SSU_XERR_ADDR)
        reg_rd = {7'h00, err_reg};
      else if (a == `SSU_NVCTL_ADDR)
        reg_rd = {7'h00, wr_en_reg};
      else if (a == `SSU_SAVE_ADDR)
        reg_rd = {7'h00, save_reg};
      else
        reg_rd = 8'h00;
    end
  endfunction

  // Serial read mux, settled long before use
  assign spi_rdata = reg_rd(spi_addr);

  // Pin sync, edge detect and frame decode
  ssu_spi_slave u_spi (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .cs_n_pin  (spi_cs_n),
    .sclk_pin  (spi_sclk),
    .sdi_pin   (spi_sdi),
    .rd_data   (spi_rdata),
    .sdo_out   (spi_sdo),
    .sdo_oe    (spi_sdo_oe),
    .sclk_rise (sclk_rise),
    .wr_stb    (spi_wr),
    .addr      (spi_addr),
    .wdata     (spi_wdata)
  );

  ////////////////////////////////////////////////////////////////////
  // Walker next state and the strobes it raises
  always @* begin
    st_next   = st_reg;
    seq_apply = 1'b0;
    seq_wr    = 1'b0;
    case (st_reg)
      S_IDLE: begin
        if (save_reg || load_req)
          st_next = S_CMD;
      end
      S_CMD: begin
        if (!cmd[`SSU_CMD_SPECIAL])
          st_next = (ptr_reg == 8'hff) ? S_IDLE : S_AHI;
        else if (cmd == `SSU_OP_APPLY) begin
          seq_apply = 1'b1;
          st_next   = (ptr_reg == 8'hff) ? S_IDLE : S_CMD;
        end else
          st_next = S_IDLE;
      end
      S_AHI:   st_next = (ptr_reg == 8'hff) ? S_IDLE : S_ALO;
      S_ALO:   st_next = (ptr_reg == 8'hff) ? S_IDLE : S_XFER;
      S_XFER:  st_next = S_WAIT;
      S_WAIT: begin
        if (nvm_ack) begin
          seq_wr  = ~dir_reg;
          st_next = (len_reg == 7'd0) ? S_CMD : S_XFER;
        end
      end
      default: st_next = S_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Walker datapath and memory port; request stands until ack
  // Saves read buffers, not the active copy
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg    <= S_IDLE;
      ptr_reg   <= 8'h00;
      len_reg   <= 7'd0;
      raddr_reg <= {`SSU_AW{1'b0}};
      dir_reg   <= 1'b0;
      busy_reg  <= 1'b0;
      err_reg   <= 1'b0;
      nvm_req   <= 1'b0;
      nvm_we    <= 1'b0;
      nvm_addr  <= {`SSU_NVM_AW{1'b0}};
      nvm_wdata <= 8'h00;
    end else begin
      st_reg <= st_next;
      case (st_reg)
        S_IDLE: begin
          if (st_next == S_CMD) begin
            busy_reg <= 1'b1;
            err_reg  <= 1'b0;
            dir_reg  <= save_reg;
            ptr_reg  <= 8'h00;
            nvm_addr <= {`SSU_NVM_AW{1'b0}};
          end
        end
        S_CMD: begin
          ptr_reg <= ptr_reg + 8'h01;
          len_reg <= cmd[6:0];
        end
        S_AHI: begin
          raddr_reg[12:8] <= cmd[4:0];
          ptr_reg         <= ptr_reg + 8'h01;
        end
        S_ALO: begin
          raddr_reg[7:0] <= cmd;
          ptr_reg        <= ptr_reg + 8'h01;
        end
        S_XFER: begin
          nvm_req   <= 1'b1;
          nvm_we    <= dir_reg;
          nvm_wdata <= reg_rd(raddr_reg);
        end
        S_WAIT: begin
          if (nvm_ack) begin
            nvm_req   <= 1'b0;
            nvm_addr  <= nvm_addr + 1'b1;
            raddr_reg <= raddr_reg + 1'b1;
            len_reg   <= len_reg - 7'd1;
            if (!dir_reg && nvm_rerr)
              err_reg <= 1'b1;
          end
        end
        default: ptr_reg <= 8'h00;
      endcase
      // List exhausted or end code: transfer complete
      if (walk_end)
        busy_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Buffer registers and list; restore writes share the port and
  // win a same-cycle collision, since the walker cannot wait
  // List writable mid-walk; rewrite it while idle
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sc_buf_reg <= `SSU_SC_RESET;
      wr_en_reg  <= 1'b0;
      for (i = 0; i < 256; i = i + 1)
        list_reg[i] <= list_init(i);
    end else if (seq_wr) begin
      if (raddr_reg == `SSU_SYSCTL_ADDR)
        sc_buf_reg <= nvm_rdata[3:0];
    end else if (spi_wr) begin
      if (spi_addr == `SSU_SYSCTL_ADDR)
        sc_buf_reg <= spi_wdata[3:0];
      else if (is_list(spi_addr))
        list_reg[spi_addr[7:0]] <= spi_wdata;
      else if (spi_addr == `SSU_NVCTL_ADDR)
        wr_en_reg <= spi_wdata[`SSU_NV_WR_EN];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Save trigger: taken only with write protection off and no
  // transfer running; stays set until the walk ends
  // Gap between transfers is the host's duty
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      save_reg <= 1'b0;
    else if (spi_wr && spi_addr == `SSU_SAVE_ADDR && spi_wdata[0]
             && wr_en_reg && !busy_reg)
      save_reg <= 1'b1;
    else if (busy_reg && walk_end)
      save_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////
  // Update request waits for the next serial rising edge; a new
  // write in the same cycle as the copy stays pending
  // The edge may fall outside any frame
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      upd_pend_reg <= 1'b0;
    else if (spi_wr && spi_addr == `SSU_APPLY_ADDR && spi_wdata[0])
      upd_pend_reg <= 1'b1;
    else if (sclk_rise)
      upd_pend_reg <= 1'b0;
  end

  // Active copy of system control
  // Both update paths load the same value
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      sc_act_reg <= `SSU_SC_RESET;
    else if ((upd_pend_reg && sclk_rise) || seq_apply)
      sc_act_reg <= sc_buf_reg;
  end

  ////////////////////////////////////////////////////////////////////
  // Analog controls and alignment, all from active bits
  // One clock behind, so each output is a flop
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      act0_d_reg   <= 1'b0;
      runt_supp_en <= 1'b1;
      sync_pd      <= 1'b0;
      dist_ref_pd  <= 1'b0;
      align_hold   <= 1'b0;
      align_event  <= 1'b0;
    end else begin
      act0_d_reg   <= sc_act_reg[`SSU_SC_SOFT_SYNC];
      runt_supp_en <= ~sc_act_reg[`SSU_SC_RUNT_DIS];
      sync_pd      <= sc_act_reg[`SSU_SC_SYNC_PD];
      dist_ref_pd  <= sc_act_reg[`SSU_SC_DIST_PD];
      // Powered-down alignment neither holds nor fires
      align_hold   <= sc_act_reg[`SSU_SC_SOFT_SYNC]
                      & ~sc_act_reg[`SSU_SC_SYNC_PD];
      align_event  <= act0_d_reg & ~sc_act_reg[`SSU_SC_SOFT_SYNC]
                      & ~sc_act_reg[`SSU_SC_SYNC_PD];
    end
  end
endmodule // ssu_settings_top

// ### src/ssu_spi_slave.v
// Serial control port: sync of pins, clock edge detect, frame decode.
// Assumes: sclk idles low, data sampled on rising, shifted on falling.
`timescale 1ns/100ps
`include "ssu_defs.vh"
module ssu_spi_slave (
  input  wire                mclk,      // Block clock
  input  wire                rst_n,     // Async reset, active low
  input  wire                cs_n_pin,  // Chip select pin, active low
  input  wire                sclk_pin,  // Serial clock pin
  input  wire                sdi_pin,   // Serial data in pin
  input  wire [7:0]          rd_data,   // Read data for addr
  output reg                 sdo_out,   // Serial data out
  output reg                 sdo_oe,    // Serial out enable
  output reg                 sclk_rise, // Pulse per serial rising edge
  output reg                 wr_stb,    // Pulse: write of wdata to addr
  output reg [`SSU_AW-1:0]   addr,      // Frame address
  output reg [7:0]           wdata      // Frame write data
);
  wire [2:0] pin_s;
  reg        sclk_d_reg;
  reg  [4:0] cnt_reg;
  reg [15:0] sh_reg;
  reg        rd_reg;
  reg  [7:0] obuf_reg;
  wire       cs_n = ~pin_s[2]; // Synced select resets to idle
  wire       rise = pin_s[1] & ~sclk_d_reg;
  wire       fall = ~pin_s[1] & sclk_d_reg;

  ssu_sync2 #(.W(3)) u_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     ({~cs_n_pin, sclk_pin, sdi_pin}),
    .q     (pin_s)
  );

  ////////////////////////////////////////////////////////////////////
  // Frame shifter; bits past one data byte are ignored
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d_reg <= 1'b0;
      cnt_reg    <= 5'd0;
      sh_reg     <= 16'h0000;
      rd_reg     <= 1'b0;
      obuf_reg   <= 8'h00;
      sdo_out    <= 1'b0;
      sdo_oe     <= 1'b0;
      sclk_rise  <= 1'b0;
      wr_stb     <= 1'b0;
      addr       <= {`SSU_AW{1'b0}};
      wdata      <= 8'h00;
    end else begin
      sclk_d_reg <= pin_s[1];
      sclk_rise  <= rise;
      wr_stb     <= 1'b0;
      if (cs_n) begin
        cnt_reg <= 5'd0;
        sdo_oe  <= 1'b0;
      end else if (rise && cnt_reg != `SSU_FRAME_BITS) begin
        sh_reg  <= {sh_reg[14:0], pin_s[0]};
        cnt_reg <= cnt_reg + 5'd1;
        if (cnt_reg == `SSU_INSTR_BITS - 5'd1) begin
          addr   <= {sh_reg[11:0], pin_s[0]};
          rd_reg <= sh_reg[14];
        end
        if (cnt_reg == `SSU_FRAME_BITS - 5'd1 && !rd_reg) begin
          wdata  <= {sh_reg[6:0], pin_s[0]};
          wr_stb <= 1'b1;
        end
      end else if (fall && rd_reg && cnt_reg >= `SSU_INSTR_BITS
                   && cnt_reg != `SSU_FRAME_BITS) begin
        sdo_oe <= 1'b1;
        if (cnt_reg == `SSU_INSTR_BITS) begin
          sdo_out  <= rd_data[7];
          obuf_reg <= {rd_data[6:0], 1'b0};
        end else begin
          sdo_out  <= obuf_reg[7];
          obuf_reg <= {obuf_reg[6:0], 1'b0};
        end
      end
    end
  end
endmodule // ssu_spi_slave

// ### src/ssu_sync2.v
// Two flip-flop synchroniser for a group of pin levels.
// Assumes: inputs are asynchronous to mclk.
`timescale 1ns/100ps
module ssu_sync2 #(
  parameter W = 3
) (
  input  wire         mclk,  // Block clock
  input  wire         rst_n, // Async reset, active low
  input  wire [W-1:0] d,     // Raw pin levels
  output reg  [W-1:0] q      // Synchronised levels
);
  reg [W-1:0] meta_reg;
  // First stage is read only by the second stage
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= {W{1'b0}};
      q        <= {W{1'b0}};
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule // ssu_sync2

// ### testbench/ssu_nvm_model.sv
// Nonvolatile memory model on the sequencer's memory port.
// Assumes: same clock as the block, one request at a time.
`timescale 1ns/100ps
module ssu_nvm_model (
  input  wire        mclk,      // Block clock
  input  wire        rst_n,     // Async reset, active low
  input  wire        nvm_req,   // Request level
  input  wire        nvm_we,    // Write request
  input  wire [9:0]  nvm_addr,  // Byte address
  input  wire [7:0]  nvm_wdata, // Write byte
  input  wire [15:0] lat,       // Answer delay in cycles
  input  wire        bad,       // Flag read data as bad
  output reg  [7:0]  nvm_rdata, // Read byte
  output reg         nvm_ack,   // Done pulse
  output reg         nvm_rerr,  // Bad data with ack
  output reg  [7:0]  req_cnt    // Requests served
);
  reg [7:0]  mem [0:1023];
  reg [15:0] wait_n;
  ////////////////////////////////////////////////////////////////////////
  // Answer after lat cycles; read data is only valid in the ack cycle,
  // outside it the bus toggles so stale data cannot pass for good data
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      nvm_ack <= 1'b0;
      nvm_rerr <= 1'b0;
      nvm_rdata <= 8'h00;
      wait_n <= 16'h0000;
      req_cnt <= 8'h00;
    end else if (nvm_req && !nvm_ack && wait_n >= lat) begin
      nvm_ack <= 1'b1;
      wait_n <= 16'h0000;
      req_cnt <= req_cnt + 8'h01;
      nvm_rdata <= mem[nvm_addr];
      nvm_rerr <= bad && !nvm_we;
      if (nvm_we) begin
        mem[nvm_addr] <= nvm_wdata;
      end
    end else begin
      nvm_ack <= 1'b0;
      nvm_rerr <= 1'b0;
      nvm_rdata <= ~nvm_rdata;
      wait_n <= (nvm_req && !nvm_ack) ? wait_n + 16'h0001 : 16'h0000;
    end
  end
endmodule // ssu_nvm_model

// ### testbench/ssu_settings_top_chk.sv
// Checker for the settings sequencer top: output events and memory port.
// Assumes: bound to every ssu_settings_top instance, ports watched by name.
`timescale 1ns/100ps
module ssu_settings_top_chk (
  input wire       mclk,         // Block clock
  input wire       rst_n,        // Async reset, active low
  input wire       spi_cs_n,     // Serial chip select
  input wire       spi_sdo_oe,   // Serial out enable
  input wire       nvm_req,      // Memory request
  input wire       nvm_we,       // Memory write flag
  input wire [9:0] nvm_addr,     // Memory address
  input wire [7:0] nvm_wdata,    // Memory write byte
  input wire       nvm_ack,      // Memory done pulse
  input wire       runt_supp_en, // Runt suppression on
  input wire       sync_pd,      // Alignment powered down
  input wire       dist_ref_pd,  // Distribution ref down
  input wire       align_hold,   // Channels held static
  input wire       align_event   // Alignment pulse
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  // Memory handshake steps
  sequence s_wait; nvm_req && !nvm_ack; endsequence
  sequence s_done; nvm_req && nvm_ack; endsequence
  // First edge after reset must still show the reset levels
  property p_rst; $rose(rst_n) |-> runt_supp_en && !sync_pd && !dist_ref_pd
    && !align_hold && !align_event && !nvm_req; endproperty
  a_rst: assert property (p_rst) else $error("reset levels wrong");
  property p_hold_pd; sync_pd |-> !align_hold; endproperty
  a_hold_pd: assert property (p_hold_pd) else $error("hold while down");
  property p_ev_pd; sync_pd |-> !align_event; endproperty
  a_ev_pd: assert property (p_ev_pd) else $error("event while down");
  property p_ev_pulse; align_event |=> !align_event; endproperty
  a_ev_pulse: assert property (p_ev_pulse) else $error("event too long");
  property p_ev_hold; align_event |-> !align_hold; endproperty
  a_ev_hold: assert property (p_ev_hold) else $error("event with hold");
  // A pending request keeps everything that qualifies it
  property p_req_stand; s_wait |=> nvm_req && $stable(nvm_we) && $stable(nvm_addr)
    && $stable(nvm_wdata); endproperty
  a_req_stand: assert property (p_req_stand) else $error("request moved");
  property p_req_drop; s_done |=> !nvm_req; endproperty
  a_req_drop: assert property (p_req_drop) else $error("request held");
  property p_oe_cs; $rose(spi_sdo_oe) |-> !spi_cs_n; endproperty
  a_oe_cs: assert property (p_oe_cs) else $error("drive outside frame");
endmodule // ssu_settings_top_chk
bind ssu_settings_top ssu_settings_top_chk chk (.mclk(mclk), .rst_n(rst_n),
  .spi_cs_n(spi_cs_n), .spi_sdo_oe(spi_sdo_oe), .nvm_req(nvm_req), .nvm_we(nvm_we),
  .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata), .nvm_ack(nvm_ack),
  .runt_supp_en(runt_supp_en), .sync_pd(sync_pd), .dist_ref_pd(dist_ref_pd),
  .align_hold(align_hold), .align_event(align_event));

// ### testbench/ssu_settings_top_tb.sv
// Self-checking bench: serial host tasks, register model, memory model.
// Assumes: design sources and ssu_defs.vh on the include path.
`timescale 1ns/100ps
`include "ssu_defs.vh"
module ssu_settings_top_tb;
  reg        mclk = 1'b0;
  reg        rst_n = 1'b0;
  reg        cs_n = 1'b1;
  reg        sclk = 1'b0;
  reg        sdi = 1'b0;
  reg [15:0] lat = 16'h0004;
  reg        bad = 1'b0;
  wire       sdo, sdo_oe, req, we, ack, rerr, runt, spd, dpd, hold, ev;
  wire [9:0] addr;
  wire [7:0] wdata, rdata, req_cnt;
  integer    bad_count = 0, num_checks = 0, ev_n = 0, ev_exp = 0, i, k;
  reg [7:0]  sc_buf = 8'h00, sc_act = 8'h00, r;
  reg [31:0] seed = 32'h324b;
  reg [7:0]  tbl [0:4];
  always #2 mclk = ~mclk;
  always @(posedge mclk) if (ev === 1'b1) ev_n = ev_n + 1;
  ssu_settings_top dut (.mclk(mclk), .rst_n(rst_n), .spi_cs_n(cs_n), .spi_sclk(sclk),
    .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(sdo_oe), .nvm_req(req), .nvm_we(we),
    .nvm_addr(addr), .nvm_wdata(wdata), .nvm_rdata(rdata), .nvm_ack(ack),
    .nvm_rerr(rerr), .runt_supp_en(runt), .sync_pd(spd), .dist_ref_pd(dpd),
    .align_hold(hold), .align_event(ev));
  ssu_nvm_model nvm (.mclk(mclk), .rst_n(rst_n), .nvm_req(req), .nvm_we(we),
    .nvm_addr(addr), .nvm_wdata(wdata), .lat(lat), .bad(bad), .nvm_rdata(rdata),
    .nvm_ack(ack), .nvm_rerr(rerr), .req_cnt(req_cnt));
  ////////////////////////////////////////////////////////////////////////
  // Comparisons and closing
  task chk_byte(input [7:0] got, input [7:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("Error at %0t: byte %h, expected %h", $time, got, exp);
      end
    end
  endtask
  // Pins and event count follow the active copy only
  task chk_pins;
    begin
      num_checks = num_checks + 1;
      if ({runt, spd, dpd, hold} !== {~sc_act[3], sc_act[2:1], sc_act[0] & ~sc_act[2]}
          || ev_n != ev_exp) begin
        bad_count = bad_count + 1;
        $display("Error at %0t: pins %b%b%b%b events %0d", $time, runt, spd, dpd, hold, ev_n);
      end
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Serial host: drive while sclk low, sample sdo at the rising edge
  task spi(input rw, input [12:0] a, input [7:0] wd, output [7:0] rd);
    reg [23:0] v;
    integer j;
    begin
      v = {rw, 2'b00, a, wd};
      rd = 8'h00;
      cs_n = 1'b0;
      for (j = 0; j < 24; j = j + 1) begin
        sdi = v[23-j];
        #62.5 sclk = 1'b1;
        if (j > 15) rd[23-j] = sdo;
        #62.5 sclk = 1'b0;
      end
      #62.5 cs_n = 1'b1;
      repeat (6) @(posedge mclk);
      #1;
    end
  endtask
  task wr(input [12:0] a, input [7:0] d);
    spi(1'b0, a, d, r);
  endtask
  task rd_chk(input [12:0] a, input [7:0] exp);
    begin
      spi(1'b1, a, 8'h00, r);
      chk_byte(r, exp);
    end
  endtask
  // Poll the status bit under a bound
  task wait_idle;
    begin
      r = 8'h01;
      for (k = 0; k < 40 && r !== 8'h00; k = k + 1) spi(1'b1, `SSU_XSTAT_ADDR, 8'h00, r);
      if (r !== 8'h00) begin
        bad_count = bad_count + 1;
        $display("Error at %0t: transfer hung", $time);
        test_done;
      end else begin
        #10000;
      end
    end
  endtask
  // Buffer write, update request, then the serial edge that performs it
  task apply(input [7:0] v);
    begin
      sc_buf = v;
      wr(`SSU_SYSCTL_ADDR, v);
      chk_pins;
      wr(`SSU_APPLY_ADDR, 8'h01);
      repeat (20) @(posedge mclk);
      chk_pins;
      #62.5 sclk = 1'b1;
      #62.5 sclk = 1'b0;
      repeat (8) @(posedge mclk);
      #1;
      if (sc_act[0] && !v[0] && !v[2]) ev_exp = ev_exp + 1;
      sc_act = v;
      chk_pins;
    end
  endtask
  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction
  // Watchdog well beyond the expected run of roughly 50k cycles
  initial begin
    #400000;
    bad_count = bad_count + 1;
    $display("Error at %0t: watchdog expired", $time);
    test_done;
  end
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    for (i = 0; i < 1024; i = i + 1) nvm.mem[i] = 8'h00;
    repeat (4) @(posedge mclk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    chk_pins;
    rd_chk(`SSU_SYSCTL_ADDR, 8'h00);
    tbl[0] = 8'h00; tbl[1] = 8'h02; tbl[2] = 8'h30; tbl[3] = 8'h80; tbl[4] = 8'hff;
    for (i = 0; i < 5; i = i + 1) rd_chk(`SSU_LIST_BASE + i, tbl[i]);
    rd_chk(`SSU_LIST_LAST, 8'hff);
    $display("reset test done");
    tbl[0] = 8'h01; tbl[1] = 8'h00; tbl[2] = 8'h05; tbl[3] = 8'h04; tbl[4] = 8'h09;
    for (i = 0; i < 5; i = i + 1) apply(tbl[i]);
    for (i = 0; i < 4; i = i + 1) begin
      seed = xs(seed);
      apply(seed[7:0] & 8'h0b);
    end
    rd_chk(`SSU_APPLY_ADDR, 8'h00);
    $display("update test done");
    wr(`SSU_SAVE_ADDR, 8'h01);
    repeat (50) @(posedge mclk);
    chk_byte(req_cnt, 8'h00);
    rd_chk(`SSU_XSTAT_ADDR, 8'h00);
    sc_buf = sc_act ^ 8'h02;
    wr(`SSU_SYSCTL_ADDR, sc_buf);
    lat = 16'd2000;
    wr(`SSU_NVCTL_ADDR, 8'h01);
    wr(`SSU_SAVE_ADDR, 8'h01);
    rd_chk(`SSU_XSTAT_ADDR, 8'h01);
    wait_idle;
    rd_chk(`SSU_SAVE_ADDR, 8'h00);
    chk_byte(nvm.mem[0], sc_buf);
    chk_byte(req_cnt, 8'h01);
    sc_act = sc_buf;
    chk_pins;
    lat = 16'h0004;
    wr(`SSU_LIST_BASE, 8'h01);
    rd_chk(`SSU_LIST_BASE, 8'h01);
    wr(`SSU_SAVE_ADDR, 8'h01);
    wait_idle;
    chk_byte(req_cnt, 8'h03);
    $display("save test done");
    wr(`SSU_LIST_BASE, 8'h00);
    nvm.mem[0] = 8'h0a;
    bad = 1'b1;
    wr(`SSU_NVCTL_ADDR, 8'h02);
    wait_idle;
    rd_chk(`SSU_SYSCTL_ADDR, 8'h0a);
    rd_chk(`SSU_XERR_ADDR, 8'h01);
    if (sc_act[0] && !sc_act[2]) ev_exp = ev_exp + 1;
    sc_act = 8'h0a;
    chk_pins;
    bad = 1'b0;
    wr(`SSU_LIST_BASE, 8'h81);
    wr(`SSU_NVCTL_ADDR, 8'h02);
    wait_idle;
    rd_chk(`SSU_XERR_ADDR, 8'h00);
    chk_byte(req_cnt, 8'h04);
    $display("restore test done");
    test_done;
  end
endmodule // ssu_settings_top_tb
